// ### verilog/spd_decoder.sv
// step pulse input decoder with idle current reduction
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module spd_decoder #(
   parameter int POS_W = 32,
   parameter int MS_CYC = spd_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // command pins: pulse/dir, clockwise/counter_clockwise, or A/B
   input wire spd_pkg::spd_pins_t cmd_pins,
   // decoded step and chain outputs
   output spd_pkg::spd_step_t step_out,
   output spd_pkg::spd_pins_t chain_pins,
   // current scale in percent of running current
   output logic [6:0] current_pct,
   output logic idle_active
);
   logic rise_a, fall_a, lvl_a, rise_b, fall_b, lvl_b;
   logic [1:0] mode_ff, nxt_mode;
   logic [1:0] fmt_ff, nxt_fmt;
   logic [1:0] cfg_ff, nxt_cfg;
   logic [6:0] pct_ff, nxt_pct;
   logic [15:0] dly_ff, nxt_dly;
   logic [31:0] rdata_ff, nxt_rdata;
   spd_pkg::spd_step_t step_ff, nxt_step;
   spd_pkg::spd_pins_t chain_ff, nxt_chain;
   logic [POS_W-1:0] pos_ff, nxt_pos;
   logic [31:0] tick_ff, nxt_tick;
   logic [15:0] ms_ff, nxt_ms;
   logic idle_ff, nxt_idle;
   logic [6:0] cur_ff, nxt_cur;
   logic quad_cw;

   // edge detectors for both command lines
   spd_edge u_edge_a (
      .core_clk(core_clk),
      .reset(reset),
      .line(cmd_pins.in_a),
      .rise(rise_a),
      .fall(fall_a),
      .level(lvl_a)
   );
   spd_edge u_edge_b (
      .core_clk(core_clk),
      .reset(reset),
      .line(cmd_pins.in_b),
      .rise(rise_b),
      .fall(fall_b),
      .level(lvl_b)
   );

   // register writes and read data; mode is one field so one mode at a time
   always_comb begin
      nxt_mode = mode_ff;
      nxt_fmt = fmt_ff;
      nxt_cfg = cfg_ff;
      nxt_pct = pct_ff;
      nxt_dly = dly_ff;
      nxt_rdata = 32'h0;
      if (reg_wr) begin
         case (reg_addr)
            spd_pkg::ADDR_MODE: begin
               nxt_mode = reg_wdata[1:0];
               // the unused fourth format code falls back to pulse and direction
               nxt_fmt = (reg_wdata[5:4] == 2'h3) ?
                         2'(spd_pkg::SPD_FMT_PULSE_DIR) : reg_wdata[5:4];
            end
            spd_pkg::ADDR_CFG: nxt_cfg = reg_wdata[1:0];
            spd_pkg::ADDR_IDLE_PCT: begin
               // percent above full current is clipped to full
               nxt_pct = (reg_wdata[6:0] > spd_pkg::IDLE_PCT_MAX) ?
                         spd_pkg::IDLE_PCT_MAX : reg_wdata[6:0];
            end
            spd_pkg::ADDR_IDLE_DLY: nxt_dly = reg_wdata[15:0];
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            spd_pkg::ADDR_MODE: nxt_rdata = {26'h0, fmt_ff, 2'h0, mode_ff};
            spd_pkg::ADDR_CFG: nxt_rdata = {30'h0, cfg_ff};
            spd_pkg::ADDR_IDLE_PCT: nxt_rdata = {25'h0, pct_ff};
            spd_pkg::ADDR_IDLE_DLY: nxt_rdata = {16'h0, dly_ff};
            spd_pkg::ADDR_STATUS: nxt_rdata = {22'h0, cur_ff, idle_ff, lvl_a, lvl_b};
            spd_pkg::ADDR_POS: nxt_rdata = 32'(pos_ff);
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   // quadrature sense: A leading B means rise of A while B low, etc.
   always_comb begin
      quad_cw = (rise_a & ~cmd_pins.in_b) | (fall_a & cmd_pins.in_b) |
                (rise_b & cmd_pins.in_a) | (fall_b & ~cmd_pins.in_a);
      if (!cfg_ff[spd_pkg::CFG_A_LEADS_CW]) begin
         quad_cw = ~quad_cw;
      end
   end

   // step decoding per input format; only position mode steps the motor
   always_comb begin
      nxt_step = '0;
      nxt_chain = chain_ff;
      if (mode_ff == 2'(spd_pkg::SPD_MODE_POSITION)) begin
         case (fmt_ff)
            2'(spd_pkg::SPD_FMT_PULSE_DIR): begin
               nxt_step.step = rise_a;
               // direction level meaning clockwise is configurable
               nxt_step.clockwise = (cmd_pins.in_b == cfg_ff[spd_pkg::CFG_DIR_HIGH_CW]);
            end
            2'(spd_pkg::SPD_FMT_DUAL_PULSE): begin
               // coincident pulses cancel rather than pick a side
               nxt_step.step = rise_a ^ rise_b;
               nxt_step.clockwise = rise_a;
            end
            2'(spd_pkg::SPD_FMT_QUADRATURE): begin
               // every edge of either channel is a count
               nxt_step.step = rise_a | fall_a | rise_b | fall_b;
               nxt_step.clockwise = quad_cw;
               nxt_chain = cmd_pins;
            end
            default: nxt_step = '0;
         endcase
      end
   end

   // position counter and idle current timer
   always_comb begin
      nxt_pos = pos_ff;
      nxt_tick = tick_ff;
      nxt_ms = ms_ff;
      nxt_idle = idle_ff;
      nxt_cur = cur_ff;
      if (step_ff.step) begin
         nxt_pos = step_ff.clockwise ? pos_ff + 1'b1 : pos_ff - 1'b1;
      end
      if (nxt_step.step) begin
         // motion restarts the delay and restores full current at once
         nxt_tick = 32'h0;
         nxt_ms = 16'h0;
         nxt_idle = 1'b0;
         nxt_cur = spd_pkg::IDLE_PCT_MAX;
      end else if (!idle_ff) begin
         if (ms_ff >= dly_ff) begin
            nxt_idle = 1'b1;
            nxt_cur = pct_ff;
         end else if (tick_ff == 32'(MS_CYC - 1)) begin
            nxt_tick = 32'h0;
            nxt_ms = ms_ff + 16'h1;
         end else begin
            nxt_tick = tick_ff + 32'h1;
         end
      end else begin
         // percent may be retuned while idle
         nxt_cur = pct_ff;
      end
   end

   // registers
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_ff <= spd_pkg::MODE_RESET;
         fmt_ff <= 2'(spd_pkg::SPD_FMT_PULSE_DIR);
         cfg_ff <= spd_pkg::CFG_RESET;
         pct_ff <= spd_pkg::IDLE_PCT_RESET;
         dly_ff <= spd_pkg::IDLE_DLY_RESET;
         rdata_ff <= 32'h0;
         step_ff <= '0;
         chain_ff <= '0;
         pos_ff <= '0;
         tick_ff <= 32'h0;
         ms_ff <= 16'h0;
         idle_ff <= 1'b0;
         cur_ff <= spd_pkg::IDLE_PCT_MAX;
      end else begin
         mode_ff <= nxt_mode;
         fmt_ff <= nxt_fmt;
         cfg_ff <= nxt_cfg;
         pct_ff <= nxt_pct;
         dly_ff <= nxt_dly;
         rdata_ff <= nxt_rdata;
         step_ff <= nxt_step;
         chain_ff <= nxt_chain;
         pos_ff <= nxt_pos;
         tick_ff <= nxt_tick;
         ms_ff <= nxt_ms;
         idle_ff <= nxt_idle;
         cur_ff <= nxt_cur;
      end
   end

   // outputs straight from flops
   assign reg_rdata = rdata_ff;
   assign step_out = step_ff;
   assign chain_pins = chain_ff;
   assign current_pct = cur_ff;
   assign idle_active = idle_ff;
endmodule : spd_decoder

// ### shared/spd_pkg.sv
// shared constants and types of the step pulse input decoder
// Overview of operation
// - four modes; only one active at once
// - pulse mode steps once per input pulse
// - setting picks direction level meaning clockwise
// - dual pulse: clockwise or counter_clockwise input steps
// - quadrature follows A/B; setting picks lead sense
// - quadrature mode re-emits encoder outputs for chaining
// - idle delay counted from when motion stops
// - idle current is programmable percent, default 50
// - quadrature counts every edge, four per line
package spd_pkg;
   // register offsets
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_CFG = 4'h1;
   localparam logic [3:0] ADDR_IDLE_PCT = 4'h2;
   localparam logic [3:0] ADDR_IDLE_DLY = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_POS = 4'h5;
   // field positions of the config register
   localparam int CFG_DIR_HIGH_CW = 0;
   localparam int CFG_A_LEADS_CW = 1;
   // reset values
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] CFG_RESET = 2'h3;
   localparam logic [6:0] IDLE_PCT_RESET = 7'h32;
   localparam logic [6:0] IDLE_PCT_MAX = 7'h64;
   localparam logic [15:0] IDLE_DLY_RESET = 16'h0064;
   // timing: idle delay is counted in milliseconds
   localparam int CLK_MHZ = 250;
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   // operating modes
   typedef enum logic [1:0] {
      SPD_MODE_POSITION,
      SPD_MODE_VELOCITY,
      SPD_MODE_SERIAL,
      SPD_MODE_HUB
   } spd_mode_t;
   // pulse input formats
   typedef enum logic [1:0] {
      SPD_FMT_PULSE_DIR,
      SPD_FMT_DUAL_PULSE,
      SPD_FMT_QUADRATURE
   } spd_fmt_t;
   // one decoded step
   typedef struct packed {
      logic step;
      logic clockwise;
   } spd_step_t;
   // the two command input lines
   typedef struct packed {
      logic in_a;
      logic in_b;
   } spd_pins_t;
endpackage : spd_pkg

// ### verilog/spd_edge.sv
// rising and falling edge detector for one synchronous input line
`timescale 1ns/1ps
module spd_edge (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // line in
   input wire logic line,
   // edges out
   output logic rise,
   output logic fall,
   output logic level
);
   logic prev_ff;
   logic nxt_prev;

   // next previous level
   always_comb begin
      nxt_prev = line;
   end

   // register previous level
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   // edges are combinational; the caller registers the outcome
   assign rise = line & ~prev_ff;
   assign fall = ~line & prev_ff;
   assign level = prev_ff;
endmodule : spd_edge

// ### test/spd_src.sv
// behavioural pulse source standing in for the indexer or master encoder
`timescale 1ns/1ps
module spd_src #(
   parameter int HP = 63
) (
   // clock
   input wire logic core_clk,
   // command pins toward the decoder
   output spd_pkg::spd_pins_t pins
);
   int ph = 0;
   initial pins = '0;
   // one motion unit; half periods of 63 cycles keep the rate under 2 MHz
   task automatic mv(input logic [1:0] fmt, input logic fwd);
      logic [1:0] seq [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
      @(posedge core_clk);
      if (fmt == 2'h2) begin
         ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
         pins <= seq[ph];
      end else begin
         if (fmt == 2'h1) pins <= {fwd, !fwd};
         else pins.in_b <= fwd;
         repeat (HP) @(posedge core_clk);
         pins.in_a <= (fmt == 2'h1) ? fwd : 1'b1;
         repeat (HP) @(posedge core_clk);
         pins <= '0;
      end
      repeat (HP) @(posedge core_clk);
   endtask : mv
endmodule : spd_src

// ### test/spd_decoder_properties.sv
// port checks of the step pulse input decoder
`timescale 1ns/1ps
module spd_decoder_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // watched ports
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire spd_pkg::spd_pins_t cmd_pins,
   input wire spd_pkg::spd_step_t step_out,
   input wire spd_pkg::spd_pins_t chain_pins,
   input wire logic [6:0] current_pct,
   input wire logic idle_active
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);
   // read data shows only in the slot after a read
   AST_RD_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside slot");
   AST_PCT_MAX: assert property (current_pct <= 7'h64)
      else $error("current above running level");
   AST_RUN: assert property (!idle_active |-> current_pct == 7'h64)
      else $error("reduced current while moving");
   AST_WAKE: assert property (step_out.step |-> !idle_active)
      else $error("step left idle reduction on");
   AST_QUIET: assert property ($rose(idle_active) |->
      !$past(step_out.step) && !$past(step_out.step, 2)) else $error("idle too soon");
   AST_ONE_STEP: assert property (step_out.step |=> !step_out.step)
      else $error("step pulse too long");
   AST_CHAIN: assert property ($changed(chain_pins) |-> chain_pins == $past(cmd_pins))
      else $error("chain output not a copy");
   AST_CAUSE: assert property (step_out.step |->
      $past(cmd_pins) != $past(cmd_pins, 2) || $past(cmd_pins, 2) != $past(cmd_pins, 3))
      else $error("step without pin edge");
   // main scenarios
   COV_STEP: cover property (step_out.step);
   COV_IDLE: cover property ($rose(idle_active));
   COV_READ: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : spd_decoder_props
bind spd_decoder spd_decoder_props chk_u (.core_clk(core_clk), .reset(reset), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cmd_pins(cmd_pins), .step_out(step_out), .chain_pins(chain_pins),
   .current_pct(current_pct), .idle_active(idle_active));

// ### test/step_pulse_input_decoder_bench.sv
// self-checking bench of the step pulse input decoder
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error %0t %h %h", $time, a, b); end end
module step_pulse_input_decoder_bench;
   logic core_clk;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   spd_pkg::spd_pins_t cmd_pins;
   spd_pkg::spd_pins_t chain_pins;
   spd_pkg::spd_step_t step_out;
   logic [6:0] current_pct;
   logic idle_active;
   logic rd_q = 1'b0;
   logic idle_q = 1'b0;
   logic got = 1'b0;
   int quiet = 0;
   logic [31:0] rq [$];
   logic sq [$];
   logic [1:0] cfg = 2'h3;
   logic [6:0] pct;
   int error_cnt = 0;
   int tests_run = 0;
   int pos_e = 0;
   spd_decoder #(.MS_CYC(4)) dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmd_pins(cmd_pins), .step_out(step_out), .chain_pins(chain_pins),
      .current_pct(current_pct), .idle_active(idle_active));
   spd_src src_u (.core_clk(core_clk), .pins(cmd_pins));
   // 4 ns clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // one write cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // one read cycle; the answer is noted for the watcher
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd
   // one motion unit; the expected sense follows the format and config bits
   task automatic mv(input logic [1:0] f, input logic fwd, input logic on);
      logic e;
      e = f == 2'h2 ? fwd == cfg[1] : f == 2'h1 ? fwd : fwd == cfg[0];
      if (on) begin
         sq.push_back(e);
         pos_e += e ? 1 : -1;
      end
      src_u.mv(f, fwd);
      // chain copy has settled long before the unit ends
      if (f == 2'h2) `CHK(chain_pins, cmd_pins)
   endtask : mv
   task automatic test_done();
      `CHK(sq.size(), 0)
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   // watcher: answers and steps are taken against the oldest note
   always @(posedge core_clk) begin : watch
      logic [31:0] exp_rd;
      logic exp_cw;
      // pop once per result so a mismatch report cannot shift the queue
      if (rd_q) begin
         exp_rd = rq.pop_front();
         `CHK(reg_rdata, exp_rd)
      end
      if (step_out.step) begin
         exp_cw = sq.size() ? sq.pop_front() : 1'bx;
         `CHK(step_out.clockwise, exp_cw)
      end
      if (idle_active && !idle_q && got) `CHK(quiet inside {[8:10]}, 1'b1)
      rd_q <= reg_rd;
      idle_q <= idle_active;
      got <= got | step_out.step;
      quiet <= step_out.step ? 0 : quiet + 1;
   end
   // main sequence
   initial begin
      int n;
      void'($urandom(32'h7785D343));
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      rd(4'h0, 32'h0);
      rd(4'h1, 32'h3);
      rd(4'h2, 32'h32);
      rd(4'h3, 32'h64);
      rd(4'hF, 32'h0);
      wr(4'h3, 32'h2);
      for (int f = 0; f < 3; f++) begin
         if (f == 2) begin
            // idle reduction to a random share, after a clipped write
            pct = 7'($urandom % 101);
            wr(4'h2, 32'h7F);
            rd(4'h2, 32'h64);
            wr(4'h2, {25'h0, pct});
            n = 0;
            while (idle_active !== 1'b1 && n < 100) begin
               @(posedge core_clk);
               n++;
            end
            repeat (2) @(posedge core_clk);
            `CHK(current_pct, pct)
            rd(4'h4, {22'h0, pct, 3'h4});
            // the unused format code falls back to pulse and direction
            wr(4'h0, 32'h31);
            rd(4'h0, 32'h1);
            // non-positioning modes must not step
            for (int m = 1; m < 4; m++) begin
               wr(4'h0, m);
               mv(2'h0, 1'b1, 1'b0);
            end
         end
         cfg = 2'($urandom);
         wr(4'h1, cfg);
         wr(4'h0, f << 4);
         repeat (6) mv(2'(f), 1'($urandom), 1'b1);
      end
      repeat (4) mv(2'h2, 1'b1, 1'b1);
      // net step count over all formats
      rd(4'h5, 32'(pos_e));
      test_done();
   end
   // watchdog, well beyond the expected run
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
endmodule : step_pulse_input_decoder_bench
